// ---- cluster_pkg.sv ----
package cluster_pkg;

    localparam int unsigned NUM_CELLS = 8;
    localparam int unsigned NUM_LINES = 4;
    localparam int unsigned NUM_SRC   = 18;

    // Word offsets of the register map, byte address is four times these
    localparam logic [3:0] OFS_CELL0   = 4'h0;
    localparam logic [3:0] OFS_LINESEL = 4'h8;
    localparam logic [3:0] OFS_CTRL    = 4'h9;
    localparam logic [3:0] OFS_STATUS  = 4'hA;

    // Positions inside the source vector of the control lines
    localparam logic [4:0] SRC_DED_BASE  = 5'h00;
    localparam logic [4:0] SRC_GLOB_BASE = 5'h02;
    localparam logic [4:0] SRC_IO_BASE   = 5'h06;
    localparam logic [4:0] SRC_CELL_BASE = 5'h0A;

    // Fields of the line select and control words
    localparam int unsigned LINESEL_W  = 5;
    localparam int unsigned CTRL_INV   = 0;
    localparam int unsigned CTRL_RSTEN = 4;
    localparam int unsigned CTRL_BREAK = 5;

    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        MODE_NORMAL, MODE_ARITH, MODE_UPDOWN, MODE_CLRCNT
    } cell_mode_e;

    typedef enum logic [1:0] {
        FF_D, FF_T, FF_JK, FF_SR
    } ff_kind_e;

    typedef enum logic [1:0] {
        CASC_START, CASC_AND, CASC_OR, CASC_SPARE
    } casc_e;

    typedef enum logic [1:0] {
        CARRY_CHAIN, CARRY_ZERO, CARRY_DATA, CARRY_SPARE
    } carry_src_e;

    typedef enum logic [2:0] {
        CP_NONE, CP_CLEAR, CP_PRESET, CP_CLEAR_PRESET,
        CP_LOAD_CLEAR, CP_LOAD_PRESET, CP_LOAD_ONLY
    } clrpre_e;

    // One cell configuration word, msb first
    typedef struct packed {
        clrpre_e     clrpre;
        logic        in_sel_carry;
        carry_src_e  carry_src;
        casc_e       casc;
        logic        ce_use;
        logic        clk_sel;
        logic        route_sel_reg;
        logic        local_sel_reg;
        ff_kind_e    ff_kind;
        cell_mode_e  mode;
        logic [15:0] lut_mask;
    } cell_cfg_s;

endpackage

// ---- logic_cluster.sv ----
module logic_cluster (
    // System
    input  wire logic                  clk_sys,
    input  wire logic                  reset,
    // Avalon-MM slave
    input  wire logic [5:0]            address,
    input  wire logic                  read,
    input  wire logic                  write,
    input  wire logic [31:0]           writedata,
    input  wire logic [3:0]            byteenable,
    output logic      [31:0]           readdata,
    output logic                       waitrequest,
    // Pins from outside the clock domain
    input  wire logic [1:0]            dedicated_clk,
    input  wire logic [3:0]            global_line,
    input  wire logic [3:0]            io_line,
    input  wire logic                  chip_reset_n,
    // Routing fabric
    input  wire logic [7:0][3:0]       cell_data,
    output logic      [7:0]            local_out,
    output logic      [7:0]            route_out,
    // Chains from and to the cluster two places along the row
    input  wire logic                  carry_in,
    input  wire logic                  cascade_in,
    output logic                       carry_out,
    output logic                       cascade_out
);

    cluster_pkg::cell_cfg_s [7:0] cfg_q;
    logic [19:0]                  linesel_q;
    logic [5:0]                   ctrl_q;
    logic [10:0]                  sync1_q;
    logic [10:0]                  sync2_q;
    logic [1:0]                   clk_prev_q;
    logic [7:0]                   q_q;
    logic [7:0]                   q_d;
    logic [7:0]                   comb_res;
    logic [7:0]                   local_q;
    logic [7:0]                   route_q;
    logic                         carry_out_q;
    logic                         cascade_out_q;
    logic [31:0]                  readdata_q;
    logic                         waitrequest_q;
    logic [8:0]                   carry;
    logic [8:0]                   casc;
    logic [3:0]                   line;
    logic [1:0]                   clk_rise;
    logic [17:0]                  src;

    function automatic logic lut3(input logic [7:0] mask, input logic [2:0] idx);
        return mask[idx];
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Pins pass two flip-flops; only the second stage is read
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sync1_q <= 11'h7FF;
            sync2_q <= 11'h7FF;
        end else begin
            sync1_q <= {chip_reset_n, io_line, global_line, dedicated_clk};
            sync2_q <= sync1_q;
        end
    end

    assign src = {local_q, sync2_q[9:0]};

    always_comb begin
        logic [4:0] sel;
        sel = 5'h00;
        for (int k = 0; k < 4; k++) begin
            sel = linesel_q[k*5 +: 5];
            if (sel >= 5'(cluster_pkg::NUM_SRC)) begin
                line[k] = 1'b1;
            end else if (k >= 2 && sel < cluster_pkg::SRC_GLOB_BASE) begin
                line[k] = 1'b1;
            end else begin
                line[k] = src[sel] ^ ctrl_q[cluster_pkg::CTRL_INV + k];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            // Lines idle high after reset; a zero here would fake a clock edge
            clk_prev_q <= 2'h3;
        end else begin
            clk_prev_q <= line[1:0];
        end
    end

    assign clk_rise = line[1:0] & ~clk_prev_q;

    // Cell datapath, chains ripple through all eight cells in one cycle
    // eight cells chained
    always_comb begin
        logic [3:0] d;
        logic       cin;
        logic       lut_o;
        logic       cout;
        logic       res;
        logic       din;
        logic       nxt;
        logic       en;
        logic       chain_ok;
        logic       a_n;
        logic       b_n;
        cluster_pkg::cell_cfg_s c;
        d        = 4'h0;
        cin      = 1'b0;
        lut_o    = 1'b0;
        cout     = 1'b0;
        res      = 1'b0;
        din      = 1'b0;
        nxt      = 1'b0;
        en       = 1'b0;
        chain_ok = 1'b0;
        a_n      = line[2];
        b_n      = line[3];
        c        = cfg_q[0];
        carry[0] = ctrl_q[cluster_pkg::CTRL_BREAK] ? 1'b0 : carry_in;
        casc[0]  = cascade_in;
        for (int i = 0; i < 8; i++) begin
            c        = cfg_q[i];
            d        = cell_data[i];
            chain_ok = (i != 0) || !ctrl_q[cluster_pkg::CTRL_BREAK];
            unique case (c.carry_src)
                cluster_pkg::CARRY_CHAIN: cin = carry[i];
                cluster_pkg::CARRY_DATA:  cin = d[2];
                default:                  cin = 1'b0;
            endcase
            unique case (c.mode)
                cluster_pkg::MODE_NORMAL: begin
                    lut_o = c.lut_mask[{d[3], c.in_sel_carry ? cin : d[2], d[1], d[0]}];
                    cout  = cin;
                end
                cluster_pkg::MODE_ARITH: begin
                    lut_o = lut3(c.lut_mask[7:0], {cin, d[1], d[0]});
                    cout  = lut3(c.lut_mask[15:8], {cin, d[1], d[0]});
                end
                cluster_pkg::MODE_UPDOWN: begin
                    lut_o = lut3(c.lut_mask[7:0], {cin, d[1], q_q[i]});
                    cout  = lut3(c.lut_mask[15:8], {cin, d[1], q_q[i]});
                end
                cluster_pkg::MODE_CLRCNT: begin
                    lut_o = lut3(c.lut_mask[7:0], {cin, 1'b0, q_q[i]});
                    cout  = lut3(c.lut_mask[15:8], {cin, 1'b0, q_q[i]});
                end
            endcase
            unique case (c.casc)
                cluster_pkg::CASC_AND: res = chain_ok ? (lut_o & casc[i]) : lut_o;
                cluster_pkg::CASC_OR:  res = chain_ok ? ~(~lut_o & ~casc[i]) : lut_o;
                default:               res = lut_o;
            endcase
            casc[i+1]   = res;
            carry[i+1]  = cout;
            comb_res[i] = res;
            unique case (c.mode)
                cluster_pkg::MODE_UPDOWN: din = d[3] ? d[2] : res;
                cluster_pkg::MODE_CLRCNT: din = (d[3] ? d[2] : res) & ~d[1];
                default:                  din = res;
            endcase
            unique case (c.ff_kind)
                cluster_pkg::FF_D:  nxt = din;
                cluster_pkg::FF_T:  nxt = q_q[i] ^ din;
                cluster_pkg::FF_JK: nxt = din ? (d[3] ? ~q_q[i] : 1'b1) : (d[3] ? 1'b0 : q_q[i]);
                cluster_pkg::FF_SR: nxt = (din && !d[3]) ? 1'b1 :
                                          ((!din && d[3]) ? 1'b0 : q_q[i]);
            endcase
            en     = !c.ce_use || d[0];
            q_d[i] = (clk_rise[c.clk_sel] && en) ? nxt : q_q[i];
            unique case (c.clrpre)
                cluster_pkg::CP_NONE: begin
                end
                cluster_pkg::CP_CLEAR: begin
                    if (!b_n) q_d[i] = 1'b0;
                end
                cluster_pkg::CP_PRESET: begin
                    if (!a_n) q_d[i] = 1'b1;
                end
                cluster_pkg::CP_CLEAR_PRESET: begin
                    if (!b_n) q_d[i] = 1'b0;
                    else if (!a_n) q_d[i] = 1'b1;
                end
                cluster_pkg::CP_LOAD_CLEAR: begin
                    if (!b_n) q_d[i] = 1'b0;
                    else if (!a_n) q_d[i] = d[2];
                end
                cluster_pkg::CP_LOAD_PRESET: begin
                    if (!b_n) q_d[i] = 1'b1;
                    else if (!a_n) q_d[i] = d[2];
                end
                cluster_pkg::CP_LOAD_ONLY: begin
                    if (!a_n) q_d[i] = d[2];
                end
                default: begin
                end
            endcase
            if (ctrl_q[cluster_pkg::CTRL_RSTEN] && !sync2_q[10]) begin
                q_d[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            q_q <= 8'h00;
        end else begin
            q_q <= q_d;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            local_q <= 8'h00;
            route_q <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                local_q[i] <= cfg_q[i].local_sel_reg ? q_d[i] : comb_res[i];
                route_q[i] <= cfg_q[i].route_sel_reg ? q_d[i] : comb_res[i];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            carry_out_q   <= 1'b0;
            cascade_out_q <= 1'b1;
        end else begin
            carry_out_q   <= carry[8];
            cascade_out_q <= casc[8];
        end
    end

    // Single wait state: request seen, answer at the next edge
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            waitrequest_q <= 1'b1;
        end else begin
            waitrequest_q <= !((read || write) && waitrequest_q);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cfg_q     <= '0;
            linesel_q <= 20'h00000;
            ctrl_q    <= 6'h00;
        end else if (write && !waitrequest_q) begin
            if (address[5:2] < cluster_pkg::OFS_LINESEL) begin
                cfg_q[address[4:2]] <= merge(cfg_q[address[4:2]], writedata, byteenable);
            end else if (address[5:2] == cluster_pkg::OFS_LINESEL) begin
                linesel_q <= 20'(merge({12'h000, linesel_q}, writedata, byteenable));
            end else if (address[5:2] == cluster_pkg::OFS_CTRL) begin
                ctrl_q <= 6'(merge({26'h0000000, ctrl_q}, writedata, byteenable));
            end
        end
    end

    // Unmapped words read zero
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            readdata_q <= cluster_pkg::RESET_WORD;
        end else if (read && waitrequest_q) begin
            if (address[5:2] < cluster_pkg::OFS_LINESEL) begin
                readdata_q <= cfg_q[address[4:2]];
            end else if (address[5:2] == cluster_pkg::OFS_LINESEL) begin
                readdata_q <= {12'h000, linesel_q};
            end else if (address[5:2] == cluster_pkg::OFS_CTRL) begin
                readdata_q <= {26'h0000000, ctrl_q};
            end else if (address[5:2] == cluster_pkg::OFS_STATUS) begin
                readdata_q <= {2'h0, line, cascade_out_q, carry_out_q,
                               route_q, local_q, q_q};
            end else begin
                readdata_q <= cluster_pkg::RESET_WORD;
            end
        end
    end

    assign readdata    = readdata_q;
    assign waitrequest = waitrequest_q;
    assign local_out   = local_q;
    assign route_out   = route_q;
    assign carry_out   = carry_out_q;
    assign cascade_out = cascade_out_q;

endmodule

// ---- fabric_model.sv ----
module fabric_model (
    // System
    input  wire logic            clk_sys,
    input  wire logic            reset,
    // Values the bench asks for
    input  wire logic [7:0][3:0] want_data,
    input  wire logic            want_carry,
    input  wire logic            want_casc,
    // Toward the cluster
    output logic      [7:0][3:0] cell_data,
    output logic                 carry_in,
    output logic                 cascade_in
);
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cell_data  <= '0;
            carry_in   <= 1'b0;
            cascade_in <= 1'b1;
        end else begin
            cell_data  <= want_data;
            carry_in   <= want_carry;
            cascade_in <= want_casc;
        end
    end
endmodule

// ---- cluster_asserts.sv ----
module cluster_asserts (
    // System
    input  wire logic            clk_sys,
    input  wire logic            reset,
    // Register bus
    input  wire logic [5:0]      address,
    input  wire logic            read,
    input  wire logic            write,
    input  wire logic [31:0]     writedata,
    input  wire logic [31:0]     readdata,
    input  wire logic            waitrequest,
    // Fabric
    input  wire logic [7:0][3:0] cell_data,
    input  wire logic [7:0]      local_out,
    input  wire logic [7:0]      route_out,
    input  wire logic            carry_in,
    input  wire logic            cascade_in,
    input  wire logic            carry_out,
    input  wire logic            cascade_out
);
    cluster_pkg::cell_cfg_s cfg_q [8];
    logic                   brk_q;
    logic [7:0]             lut, norm, byp_l, byp_r, chain, cand;

    // Mirror assumes whole-word writes only
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cfg_q <= '{default: '0};
            brk_q <= 1'b0;
        end else if (write && !waitrequest) begin
            if (!address[5]) begin
                cfg_q[address[4:2]] <= cluster_pkg::cell_cfg_s'(writedata);
            end
            if (address[5:2] == cluster_pkg::OFS_CTRL) begin
                brk_q <= writedata[cluster_pkg::CTRL_BREAK];
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            lut[i]   = cfg_q[i].lut_mask[cell_data[i]];
            norm[i]  = cfg_q[i].mode == cluster_pkg::MODE_NORMAL && !cfg_q[i].in_sel_carry;
            chain[i] = norm[i] && cfg_q[i].carry_src == cluster_pkg::CARRY_CHAIN;
            cand[i]  = norm[i] && cfg_q[i].casc == cluster_pkg::CASC_AND;
            // Codes 0 and 3 both start a chain
            byp_l[i] = norm[i] && cfg_q[i].casc[0] == cfg_q[i].casc[1]
                       && !cfg_q[i].local_sel_reg;
            byp_r[i] = norm[i] && cfg_q[i].casc[0] == cfg_q[i].casc[1]
                       && !cfg_q[i].route_sel_reg;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    chk_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("bus request not answered");
    chk_wait_single: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low too long");
    chk_wait_idle: assert property (!read && !write |=> waitrequest)
        else $error("answer without request");
    chk_rdata_hold: assert property (!(read && waitrequest) |=> $stable(readdata))
        else $error("readdata moved without read");
    chk_local_bypass: assert property (1'b1 |=> ((local_out ^ $past(lut)) & $past(byp_l)) == 8'h00)
        else $error("local output not table result");
    chk_route_indep: assert property (1'b1 |=> ((route_out ^ $past(lut)) & $past(byp_r)) == 8'h00)
        else $error("route output not table result");
    chk_carry_pass: assert property (&chain && !brk_q |=> carry_out == $past(carry_in))
        else $error("carry not passed through");
    chk_row_break: assert property (&chain && brk_q |=> !carry_out)
        else $error("carry crossed row break");
    chk_cascade_and: assert property (&cand && !brk_q |=> cascade_out == $past(cascade_in && &lut))
        else $error("cascade AND wrong");
    chk_cascade_start: assert property (&cand && brk_q |=> cascade_out == $past(&lut))
        else $error("cascade start not neutral");
endmodule

bind logic_cluster cluster_asserts i_cluster_asserts (.clk_sys, .reset, .address, .read, .write,
    .writedata, .readdata, .waitrequest, .cell_data, .local_out, .route_out, .carry_in,
    .cascade_in, .carry_out, .cascade_out);

// ---- tb.sv ----
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic            clk_sys, reset, read, write, waitrequest, chip_reset_n;
    logic            carry_in, cascade_in, carry_out, cascade_out, want_carry, want_casc;
    logic [5:0]      address;
    logic [31:0]     writedata, readdata, rd;
    logic [3:0]      byteenable, global_line, io_line;
    logic [1:0]      dedicated_clk;
    logic [7:0][3:0] cell_data, want_data;
    logic [7:0]      local_out, route_out;
    logic [15:0]     masks [8];
    int              seed, n_mismatch, checks;

    logic_cluster i_logic_cluster (.clk_sys, .reset, .address, .read, .write, .writedata,
        .byteenable, .readdata, .waitrequest, .dedicated_clk, .global_line, .io_line,
        .chip_reset_n, .cell_data, .local_out, .route_out, .carry_in, .cascade_in,
        .carry_out, .cascade_out);
    fabric_model i_fabric_model (.clk_sys, .reset, .want_data, .want_carry, .want_casc,
        .cell_data, .carry_in, .cascade_in);

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic wait_ack;
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        if (waitrequest !== 1'b0) begin
            n_mismatch++;
            tally_and_finish;
        end
    endtask

    task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        address <= a;
        writedata <= d;
        write <= 1'b1;
        wait_ack;
        write <= 1'b0;
    endtask

    task automatic bus_rd(input logic [5:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        address <= a;
        read <= 1'b1;
        wait_ack;
        d = readdata;
        read <= 1'b0;
    endtask

    task automatic check_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_out(input int kind, input logic [9:0] exp, input logic [9:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch outputs kind %0d expected %h seen %h", kind, exp, got);
        end
    endtask

    // Kind 0 table, 1 cascade, 2 adder; result is {cascade, carry, local}
    function automatic logic [9:0] expect_out(input int kind, input logic brk,
                                              input logic [7:0][3:0] d, input logic ci,
                                              input logic ki);
        logic [7:0] t, a, b;
        for (int i = 0; i < 8; i++) begin
            t[i] = masks[i][d[i]];
            a[i] = d[i][0];
            b[i] = d[i][1];
        end
        case (kind)
            0: return {1'b0, ci, t};
            1: return {(brk | ki) & (&t), ~brk & ci, 8'h00};
            default: return {1'b0, 9'(a) + 9'(b)};
        endcase
    endfunction

    task automatic run(input int kind, input logic brk, input logic [9:0] m);
        logic [9:0]  e;
        logic [31:0] w;
        for (int i = 0; i < 8; i++) begin
            masks[i] = (kind == 2) ? 16'hE896 : 16'($random(seed));
            w = (kind == 1) ? 32'h0100_0000 : (kind == 2) ? 32'h0001_0000 : 32'h0000_0000;
            // Adder low bit starts from a zero carry
            if (kind == 2 && i == 0) begin
                w = w | 32'h0400_0000;
            end
            w = w | 32'(masks[i]);
            bus_wr(6'(4 * i), w);
        end
        bus_wr(6'h24, {26'h0000000, brk, 5'h00});
        bus_rd(6'h1C, rd);
        check_reg("cell7 config", w, rd);
        for (int t = 0; t < 40; t++) begin
            @(posedge clk_sys);
            if (t > 1) begin
                check_out(kind, e & m, {cascade_out, carry_out, local_out} & m);
                check_out(kind, e & m, {cascade_out, carry_out, route_out} & m);
            end
            e = expect_out(kind, brk, cell_data, carry_in, cascade_in);
            want_data <= $random(seed);
            {want_carry, want_casc} <= 2'($random(seed));
            {chip_reset_n, dedicated_clk, global_line, io_line} <= 11'($random(seed));
        end
        $display("test kind %0d break %0d done", kind, brk);
    endtask

    initial begin
        seed = 26;
        n_mismatch = 0;
        checks = 0;
        reset = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 6'h00;
        writedata = 32'h0000_0000;
        byteenable = 4'hF;
        {chip_reset_n, dedicated_clk, global_line, io_line} = 11'h400;
        want_data = '0;
        want_carry = 1'b0;
        want_casc = 1'b1;
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        bus_rd(6'h00, rd);
        check_reg("cell0 config after reset", 32'h0000_0000, rd);
        bus_wr(6'h2C, 32'hFFFF_FFFF);
        bus_rd(6'h2C, rd);
        check_reg("unmapped word", 32'h0000_0000, rd);
        $display("test registers done");
        run(0, 1'b0, 10'h1FF);
        run(1, 1'b0, 10'h300);
        run(1, 1'b1, 10'h300);
        run(2, 1'b0, 10'h1FF);
        tally_and_finish;
    end
endmodule
